// ===== src/nfh_pkg.sv
// Constants, types and helpers for the host-side NAND flash sequencer.
package nfh_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned T_ADL_NS = 70;
   localparam int unsigned T_WB_NS = 100;
   localparam int unsigned T_RHW_NS = 100;
   localparam int unsigned T_R_NS = 25000;
   localparam int unsigned T_R_ECC_NS = 70000;
   localparam int unsigned T_PROG_NS = 600000;
   localparam int unsigned T_CBSY_NS = 600000;
   localparam int unsigned T_RCBSY_NS = 25000;
   localparam int unsigned T_BERS_NS = 3000000;
   localparam int unsigned T_FEAT_NS = 1000;
   localparam int unsigned T_DBSY_NS = 1000;
   localparam int unsigned T_RST_FIRST_NS = 1000000;
   localparam int unsigned T_RST_NS = 5000;
   localparam int unsigned T_RST_RD_NS = 5000;
   localparam int unsigned T_RST_PG_NS = 10000;
   localparam int unsigned T_RST_ER_NS = 500000;

   // Least times round up, longest times round down
   localparam int unsigned ADL_CYC = (T_ADL_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RHW_CYC = (T_RHW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned R_CYC = T_R_NS / CLK_NS;
   localparam int unsigned R_ECC_CYC = T_R_ECC_NS / CLK_NS;
   localparam int unsigned PROG_CYC = T_PROG_NS / CLK_NS;
   localparam int unsigned CBSY_CYC = T_CBSY_NS / CLK_NS;
   localparam int unsigned RCBSY_CYC = T_RCBSY_NS / CLK_NS;
   localparam int unsigned BERS_CYC = T_BERS_NS / CLK_NS;
   localparam int unsigned FEAT_CYC = T_FEAT_NS / CLK_NS;
   localparam int unsigned DBSY_CYC = T_DBSY_NS / CLK_NS;
   localparam int unsigned RST_FIRST_CYC = T_RST_FIRST_NS / CLK_NS;
   localparam int unsigned RST_CYC = T_RST_NS / CLK_NS;
   localparam int unsigned RST_RD_CYC = T_RST_RD_NS / CLK_NS;
   localparam int unsigned RST_PG_CYC = T_RST_PG_NS / CLK_NS;
   localparam int unsigned RST_ER_CYC = T_RST_ER_NS / CLK_NS;
   localparam int unsigned TMR_W = 19;

   // Strobe phases: write low in phases 1..WR_LOW, read low in 1..RD_LOW
   localparam int unsigned PH_W = 4;
   localparam logic [PH_W-1:0] WR_LOW = 4'h2;
   localparam logic [PH_W-1:0] WR_LAST = 4'h3;
   localparam logic [PH_W-1:0] RD_LOW = 4'h7;
   localparam logic [PH_W-1:0] RD_LAST = 4'h9;

   localparam logic [2:0] NOP_LIMIT = 3'h4;
   localparam logic [2:0] ADDR_LAST = 3'h4;
   localparam logic [2:0] ROW_FIRST = 3'h2;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_RESET, OP_READ, OP_CACHE_READ, OP_PROGRAM, OP_CACHE_PROG,
      OP_PLANE_STEP, OP_ERASE, OP_FEAT_SET, OP_FEAT_GET, OP_OTP_PROG
   } nfh_op_e;

   typedef struct packed {
      nfh_op_e op;
      logic [7:0] cmd1;
      logic [7:0] cmd2;
      logic has_cmd2;
      logic [10:0] col;
      logic [5:0] page;
      logic [11:0] block;
      logic [10:0] nwords;
   } nfh_cmd_s;

   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
      logic io_oe_n;
      logic [15:0] io;
   } nfh_pins_s;

   function automatic logic [2:0] nfh_naddr(input nfh_op_e op);
      case (op)
         OP_RESET, OP_CACHE_READ: return 3'h0;
         OP_FEAT_SET, OP_FEAT_GET: return 3'h1;
         OP_ERASE: return 3'h3;
         default: return 3'h5;
      endcase
   endfunction

   function automatic logic nfh_is_prog(input nfh_op_e op);
      return op == OP_PROGRAM || op == OP_CACHE_PROG || op == OP_PLANE_STEP
         || op == OP_OTP_PROG;
   endfunction

   function automatic logic nfh_rdata(input nfh_op_e op);
      return op == OP_READ || op == OP_CACHE_READ || op == OP_FEAT_GET;
   endfunction

endpackage

// ===== src/nfh_ctrl.sv
// Host sequencer driving an asynchronous x16 NAND flash die through its pins.
module nfh_ctrl
   import nfh_pkg::*;
#(
   parameter int unsigned R_ECC_LIM = R_ECC_CYC,
   parameter int unsigned PROG_LIM = PROG_CYC,
   parameter int unsigned CBSY_LIM = CBSY_CYC,
   parameter int unsigned BERS_LIM = BERS_CYC,
   parameter int unsigned RST_FIRST_LIM = RST_FIRST_CYC,
   parameter int unsigned RST_ER_LIM = RST_ER_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire nfh_cmd_s cmd,
   input wire logic ecc_on,
   // Write data
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [15:0] wr_data,
   // Read data
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [15:0] rd_data,
   // Completion
   output logic done,
   output logic done_timeout,
   output logic done_refused,
   output logic busy,
   // Flash pins
   output logic nand_ce_n,
   output logic nand_cle,
   output logic nand_ale,
   output logic nand_we_n,
   output logic read_strobe_n,
   output logic [15:0] nand_io_out,
   output logic nand_io_oe_n,
   input wire logic [15:0] nand_io_in,
   input wire logic nand_rb_n
);

   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD1, ST_ADDR, ST_ADL, ST_WDATA, ST_CMD2, ST_WB, ST_BUSY,
      ST_RDATA, ST_TAIL
   } nfh_st_e;

   nfh_st_e state;
   nfh_cmd_s cur;
   nfh_pins_s pins;
   nfh_pins_s next_pins;
   logic [PH_W-1:0] ph;
   logic [2:0] aidx;
   logic [2:0] aend;
   logic [10:0] wcnt;
   logic [15:0] wdat;
   logic [TMR_W-1:0] tmr;
   logic [TMR_W-1:0] limit;
   logic reset_seen;
   logic aborting;
   nfh_op_e abort_op;
   logic [17:0] pp_page;
   logic [2:0] pp_cnt;
   logic [3:0] pp_mask;
   logic rb_s1, rb_s2, rb_s3, rdy;
   logic [15:0] io_s1, io_s2, io_s3, io_val;
   logic [15:0] rbuf [2];
   logic wp, rp;
   logic [1:0] cnt;
   logic take, refuse, cyc_end, rd_push, rd_pop;
   logic [3:0] area;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
         rb_s3 <= 1'b1;
         rdy <= 1'b1;
         io_s1 <= 16'h0000;
         io_s2 <= 16'h0000;
         io_s3 <= 16'h0000;
         io_val <= 16'h0000;
      end
      else
      begin
         rb_s1 <= nand_rb_n;
         rb_s2 <= rb_s1;
         rb_s3 <= rb_s2;
         if (rb_s2 == rb_s3)
            rdy <= rb_s3;
         io_s1 <= nand_io_in;
         io_s2 <= io_s1;
         io_s3 <= io_s2;
         if (io_s2 == io_s3)
            io_val <= io_s3;
      end
   end

   // ----------------------------------------------------------------------
   // Handshakes and busy budget
   // ----------------------------------------------------------------------
   assign cmd_ready = (state == ST_IDLE) || (state == ST_BUSY && cmd.op == OP_RESET);
   assign take = cmd_valid && cmd_ready;
   assign area = 4'h1 << cmd.col[9:8];
   // Only the most recently programmed page is tracked, a cheap guard
   // that catches the common back-to-back partial program pattern
   assign refuse = state == ST_IDLE && ((!reset_seen && cmd.op != OP_RESET)
      || (nfh_is_prog(cmd.op) && pp_page == {cmd.block, cmd.page}
      && (pp_cnt >= NOP_LIMIT
      || (ecc_on && (pp_mask & area) != 4'h0))));
   assign wr_ready = state == ST_WDATA && ph == '0;
   assign cyc_end = (state == ST_RDATA) ? ph == RD_LAST : ph == WR_LAST;
   assign rd_push = state == ST_RDATA && ph == RD_LAST;
   assign rd_pop = rd_valid && rd_ready;
   assign rd_valid = cnt != 2'h0;
   assign rd_data = rbuf[rp];
   assign busy = state != ST_IDLE;

   function automatic logic [TMR_W-1:0] busy_limit(input nfh_op_e op, input logic ecc,
         input logic first, input logic abt, input nfh_op_e aop);
      int unsigned l;
      case (op)
         OP_RESET:
            if (first)
               l = RST_FIRST_LIM;
            else if (abt && (aop == OP_READ || aop == OP_CACHE_READ))
               l = RST_RD_CYC;
            else if (abt && nfh_is_prog(aop))
               l = RST_PG_CYC;
            else if (abt && aop == OP_ERASE)
               l = RST_ER_LIM;
            else
               l = RST_CYC;
         OP_READ: l = ecc ? R_ECC_LIM : R_CYC;
         OP_CACHE_READ: l = RCBSY_CYC;
         OP_CACHE_PROG: l = CBSY_LIM;
         OP_PLANE_STEP: l = DBSY_CYC;
         OP_ERASE: l = BERS_LIM;
         OP_FEAT_SET, OP_FEAT_GET: l = FEAT_CYC;
         // Locked-block and protected-area rejections end well inside this budget
         default: l = PROG_LIM;
      endcase
      return TMR_W'(l);
   endfunction

   function automatic logic [7:0] addr_byte(input nfh_cmd_s c, input logic [2:0] i);
      logic [10:0] col;
      col = c.col[10] ? {c.col[10], 5'h00, c.col[4:0]} : c.col;
      case (i)
         3'h0: return col[7:0];
         3'h1: return {5'h00, col[10:8]};
         3'h2: return {c.block[1:0], c.page};
         3'h3: return c.block[9:2];
         default: return {6'h00, c.block[11:10]};
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= ST_IDLE;
         cur <= '0;
         ph <= '0;
         aidx <= 3'h0;
         aend <= 3'h0;
         wcnt <= 11'h000;
         wdat <= 16'h0000;
         tmr <= '0;
         limit <= '0;
         reset_seen <= 1'b0;
         aborting <= 1'b0;
         abort_op <= OP_RESET;
         done <= 1'b0;
         done_timeout <= 1'b0;
         done_refused <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         done_timeout <= 1'b0;
         done_refused <= 1'b0;
         ph <= (state == ST_WDATA && ph == '0 && !wr_valid)
            || (state == ST_RDATA && ph == '0 && cnt == 2'h2) || cyc_end
            || !(state inside {ST_CMD1, ST_ADDR, ST_WDATA, ST_CMD2, ST_RDATA})
            ? '0 : ph + 1'b1;
         if (wr_valid && wr_ready)
            wdat <= wr_data;
         case (state)
            ST_IDLE:
               if (take && refuse)
               begin
                  done <= 1'b1;
                  done_refused <= 1'b1;
               end
               else if (take)
               begin
                  cur <= cmd;
                  aborting <= 1'b0;
                  tmr <= '0;
                  limit <= busy_limit(cmd.op, ecc_on, !reset_seen, 1'b0, OP_RESET);
                  aidx <= nfh_naddr(cmd.op) == 3'h3 ? ROW_FIRST : 3'h0;
                  aend <= nfh_naddr(cmd.op) == 3'h3 ? ADDR_LAST : nfh_naddr(cmd.op) - 1'b1;
                  wcnt <= cmd.nwords;
                  state <= ST_CMD1;
               end
            ST_CMD1:
               if (cyc_end)
                  state <= cur.op == OP_RESET || nfh_naddr(cur.op) == 3'h0
                     ? (cur.has_cmd2 ? ST_CMD2 : ST_WB) : ST_ADDR;
            ST_ADDR:
               if (cyc_end && aidx != aend)
                  aidx <= aidx + 1'b1;
               else if (cyc_end)
               begin
                  tmr <= '0;
                  state <= (!nfh_rdata(cur.op) && cur.nwords != 11'h000) ? ST_ADL
                     : (cur.has_cmd2 ? ST_CMD2 : ST_WB);
               end
            ST_ADL:
               if (tmr >= TMR_W'(ADL_CYC))
                  state <= ST_WDATA;
               else
                  tmr <= tmr + 1'b1;
            ST_WDATA:
               if (cyc_end)
               begin
                  wcnt <= wcnt - 1'b1;
                  if (wcnt == 11'h001)
                  begin
                     // The write-to-busy wait must not inherit the address gap count
                     tmr <= '0;
                     state <= cur.has_cmd2 ? ST_CMD2 : ST_WB;
                  end
               end
            ST_CMD2:
               if (cyc_end)
                  state <= ST_WB;
            ST_WB:
               // Ready/busy is only trusted once the device has had time to drop it
               if (tmr >= TMR_W'(WB_CYC))
                  state <= ST_BUSY;
               else
                  tmr <= tmr + 1'b1;
            ST_BUSY:
               if (take)
               begin
                  cur <= cmd;
                  aborting <= 1'b1;
                  tmr <= '0;
                  abort_op <= cur.op;
                  limit <= busy_limit(OP_RESET, ecc_on, 1'b0, 1'b1, cur.op);
                  state <= ST_CMD1;
               end
               else if (rdy)
               begin
                  if (cur.op == OP_RESET)
                     reset_seen <= 1'b1;
                  if (nfh_rdata(cur.op) && cur.nwords != 11'h000)
                     state <= ST_RDATA;
                  else
                  begin
                     done <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
               else if (tmr >= limit)
               begin
                  done <= 1'b1;
                  done_timeout <= 1'b1;
                  state <= ST_IDLE;
               end
               else
                  tmr <= tmr + 1'b1;
            ST_RDATA:
               if (cyc_end)
               begin
                  wcnt <= wcnt - 1'b1;
                  tmr <= '0;
                  if (wcnt == 11'h001)
                     state <= ST_TAIL;
               end
            default:
               // Keeps the next write strobe clear of the last read strobe
               if (tmr >= TMR_W'(RHW_CYC))
               begin
                  done <= 1'b1;
                  state <= ST_IDLE;
               end
               else
                  tmr <= tmr + 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Partial program bookkeeping
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pp_page <= 18'h00000;
         pp_cnt <= 3'h0;
         pp_mask <= 4'h0;
      end
      else if (take && !refuse && state == ST_IDLE && nfh_is_prog(cmd.op))
      begin
         pp_page <= {cmd.block, cmd.page};
         pp_cnt <= pp_page == {cmd.block, cmd.page} ? pp_cnt + 1'b1 : 3'h1;
         pp_mask <= pp_page == {cmd.block, cmd.page} ? pp_mask | area : area;
      end
      else if (take && cmd.op == OP_ERASE && pp_page[17:6] == cmd.block)
      begin
         pp_cnt <= 3'h0;
         pp_mask <= 4'h0;
      end
   end

   // ----------------------------------------------------------------------
   // Read buffer, two entries
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wp <= 1'b0;
         rp <= 1'b0;
         cnt <= 2'h0;
         rbuf[0] <= 16'h0000;
         rbuf[1] <= 16'h0000;
      end
      else
      begin
         if (rd_push)
         begin
            rbuf[wp] <= io_val;
            wp <= ~wp;
         end
         if (rd_pop)
            rp <= ~rp;
         cnt <= cnt + {1'b0, rd_push} - {1'b0, rd_pop};
      end
   end

   // ----------------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_pins = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
         io_oe_n: 1'b1, io: 16'h0000};
      next_pins.ce_n = state == ST_IDLE;
      case (state)
         ST_CMD1, ST_CMD2:
         begin
            next_pins.cle = 1'b1;
            next_pins.io_oe_n = 1'b0;
            next_pins.io = {8'h00, state == ST_CMD1 ? cur.cmd1 : cur.cmd2};
            next_pins.we_n = !(ph != '0 && ph <= WR_LOW);
         end
         ST_ADDR:
         begin
            next_pins.ale = 1'b1;
            next_pins.io_oe_n = 1'b0;
            next_pins.io = {8'h00, addr_byte(cur, aidx)};
            next_pins.we_n = !(ph != '0 && ph <= WR_LOW);
         end
         ST_WDATA:
         begin
            next_pins.io_oe_n = 1'b0;
            next_pins.io = wdat;
            next_pins.we_n = !(ph != '0 && ph <= WR_LOW);
         end
         ST_RDATA:
            next_pins.re_n = !(ph != '0 && ph <= RD_LOW);
         default:
            next_pins.io = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
            io_oe_n: 1'b1, io: 16'h0000};
      else
         pins <= next_pins;
   end

   assign nand_ce_n = pins.ce_n;
   assign nand_cle = pins.cle;
   assign nand_ale = pins.ale;
   assign nand_we_n = pins.we_n;
   assign read_strobe_n = pins.re_n;
   assign nand_io_out = pins.io;
   assign nand_io_oe_n = pins.io_oe_n;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   logic we_q;
   logic last_addr;
   logic [7:0] gap;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         we_q <= 1'b1;
         last_addr <= 1'b0;
         gap <= 8'hFF;
      end
      else
      begin
         we_q <= pins.we_n;
         if (pins.we_n && !we_q)
         begin
            last_addr <= pins.ale;
            gap <= 8'h00;
         end
         else if (gap != 8'hFF)
            gap <= gap + 1'b1;
      end
   end

   a_addr_upper_low:
   assert property (pins.ale && !pins.io_oe_n |-> pins.io[15:8] == 8'h00)
      else $error("address cycle drives upper byte");
   a_spare_col_zero:
   assert property (state == ST_ADDR && aidx == 3'h0 && cur.col[10] |=> pins.io[7:5] == 3'h0)
      else $error("spare column drives bits 7 to 5");
   a_adl_gap:
   assert property (pins.we_n && !we_q && !pins.ale && !pins.cle && last_addr
      |-> gap >= 8'(ADL_CYC))
      else $error("data write too soon after address");
   a_reset_first:
   assert property (state == ST_CMD1 && !reset_seen |-> cur.op == OP_RESET)
      else $error("command before first reset");
   a_refuse_early:
   assert property (take && state == ST_IDLE && !reset_seen && cmd.op != OP_RESET
      |=> done && done_refused && state == ST_IDLE)
      else $error("early command not refused");
   a_nop_bound:
   assert property (state == ST_CMD1 && nfh_is_prog(cur.op) |-> pp_cnt <= NOP_LIMIT)
      else $error("partial program limit passed");
   a_busy_timeout:
   assert property (state == ST_BUSY && !take && !rdy && tmr >= limit
      |=> done && done_timeout ##1 !done)
      else $error("timeout not reported");
   a_ready_exit:
   assert property (state == ST_BUSY && rdy && !take |=> state != ST_BUSY)
      else $error("ready ignored");
   a_we_low_width:
   assert property ($fell(pins.we_n) |=> !pins.we_n ##1 pins.we_n)
      else $error("write strobe width wrong");
   a_rd_hold:
   assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read word lost under stall");

   c_reset_done: cover property (state == ST_BUSY && cur.op == OP_RESET && rdy);
   c_read_stall: cover property (state == ST_RDATA && cnt == 2'h2);
   c_timeout: cover property (done && done_timeout);
   c_abort: cover property (state == ST_BUSY && take);

endmodule // nfh_ctrl

// ===== testbench/nfh_flash_model.sv
// Behavioural flash die seen from its pins, for the host sequencer bench
module nfh_flash_model (
   // Busy timing
   input wire logic clk,
   input wire logic [31:0] busy_cyc,
   // Pins
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic [15:0] io_out,
   output logic [15:0] io_in,
   output logic rb_n,
   // Observation
   output logic [79:0] addr_seen,
   output logic [7:0] last_cmd,
   output logic adl_short,
   output logic [15:0] data_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   int bcnt = 0;
   logic [15:0] nrd = 16'h0000;
   logic drv = 1'b0;
   logic data_ph = 1'b0;
   realtime t_adr = 0;
   initial
   begin
      addr_seen = '0;
      last_cmd = 8'h00;
      adl_short = 1'b0;
      data_seen = 16'h0000;
   end
   assign rb_n = (bcnt == 0);
   // Released bus shows the inverse so a late sample cannot pass
   assign io_in = drv ? 16'hA500 + nrd : ~(16'hA500 + nrd);
   always @(negedge re_n) if (!ce_n) drv = 1'b1;
   always @(posedge re_n)
   begin
      drv <= #15 1'b0;
      nrd <= #15 nrd + 16'h0001;
   end
   always @(posedge clk) if (bcnt > 0) bcnt = bcnt - 1;
   always @(posedge we_n) if (!ce_n)
   begin
      if (cle)
      begin
         last_cmd = io_out[7:0];
         nrd = 16'h0000;
         data_ph = 1'b0;
         if (io_out[7:0] inside {8'hFF, 8'h30, 8'h10, 8'h15, 8'hD0, 8'h11})
            bcnt = busy_cyc;
      end
      else if (ale)
      begin
         addr_seen = {io_out, addr_seen[79:16]};
         t_adr = $realtime;
         data_ph = 1'b1;
      end
      else
      begin
         if (data_ph && $realtime - t_adr < 70.0) adl_short = 1'b1;
         data_ph = 1'b0;
         data_seen = io_out;
      end
   end
endmodule // nfh_flash_model

// ===== testbench/tb_top.sv
// Self-checking bench for the host flash sequencer
module tb_top
   import nfh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0;
   logic rstn = 0;
   logic cmd_valid = 0;
   logic wr_valid = 1;
   logic rd_ready = 0;
   logic ecc_on = 0;
   logic stall = 0;
   nfh_cmd_s cmd = '0;
   logic [15:0] wr_data = 16'h0000;
   logic cmd_ready, wr_ready, rd_valid, done, done_timeout, done_refused, busy;
   logic [15:0] rd_data, nand_io_out, nand_io_in;
   logic nand_ce_n, nand_cle, nand_ale, nand_we_n, read_strobe_n, nand_io_oe_n, nand_rb_n;
   logic [79:0] addr_seen;
   logic [7:0] last_cmd;
   logic [15:0] data_seen;
   logic adl_short, to_seen, ref_seen;
   int busy_cyc = 40;
   int bad_count = 0;
   int check_count = 0;
   int dur;
   logic [15:0] rx[$];

   nfh_ctrl #(.PROG_LIM(200), .CBSY_LIM(200), .BERS_LIM(200),
      .RST_FIRST_LIM(200), .RST_ER_LIM(200)) u_dut (.clk(clk), .rstn(rstn),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .ecc_on(ecc_on),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .done(done), .done_timeout(done_timeout),
      .done_refused(done_refused), .busy(busy), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle),
      .nand_ale(nand_ale), .nand_we_n(nand_we_n), .read_strobe_n(read_strobe_n),
      .nand_io_out(nand_io_out), .nand_io_oe_n(nand_io_oe_n), .nand_io_in(nand_io_in),
      .nand_rb_n(nand_rb_n));
   nfh_flash_model u_flash (.clk(clk), .busy_cyc(busy_cyc), .ce_n(nand_ce_n), .cle(nand_cle),
      .ale(nand_ale), .we_n(nand_we_n), .re_n(read_strobe_n), .io_out(nand_io_out),
      .io_in(nand_io_in), .rb_n(nand_rb_n), .addr_seen(addr_seen), .last_cmd(last_cmd),
      .adl_short(adl_short), .data_seen(data_seen));

   initial forever #4 clk = ~clk;
   // Reader stalls every other cycle, and fully while stall is set
   always @(posedge clk)
   begin
      if (wr_valid && wr_ready) wr_data <= wr_data + 16'h0001;
      if (rd_valid && rd_ready) rx.push_back(rd_data);
      rd_ready <= !stall && !rd_ready;
   end

   task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string what);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask

   function automatic logic [79:0] addr_exp(input logic [10:0] col, input logic [11:0] blk);
      logic [10:0] c;
      c = col[10] ? {col[10], 5'h00, col[4:0]} : col;
      return {14'h0, blk[11:10], 8'h00, blk[9:2], 8'h00, blk[1:0], 6'h2A,
         13'h0, c[10:8], 8'h00, c[7:0]};
   endfunction

   task automatic issue(input nfh_op_e op, input logic [7:0] c1, input logic [7:0] c2,
      input logic [10:0] col, input logic [11:0] blk, input logic [10:0] nw);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{op, c1, c2, c2 != 8'h00, col, 6'h2A, blk, nw};
      do @(posedge clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      for (dur = 0; dur < 4000 && done !== 1'b1; dur++) @(posedge clk);
      to_seen = done_timeout;
      ref_seen = done_refused;
   endtask

   task automatic t_first_reset;
      issue(OP_READ, 8'h00, 8'h30, 11'h000, 12'h000, 11'h001);
      check(ref_seen, 1'b1, "read accepted before reset");
      issue(OP_RESET, 8'hFF, 8'h00, 11'h000, 12'h000, 11'h000);
      check({to_seen, ref_seen}, 2'b00, "reset ended badly");
      check(dur >= busy_cyc, 1'b1, "ready line not awaited");
   endtask

   task automatic t_read;
      rx.delete();
      stall <= 1'b1;
      fork
         begin
            repeat (300) @(posedge clk);
            stall <= 1'b0;
         end
      join_none
      issue(OP_READ, 8'h00, 8'h30, 11'h4FF, 12'hABC, 11'h006);
      check(addr_seen, addr_exp(11'h4FF, 12'hABC), "read address cycles");
      repeat (20) @(posedge clk);
      check(rx.size(), 6, "read word count");
      for (int i = 0; i < 6; i++) check(rx[i], 16'hA500 + i, "read word");
   endtask

   task automatic t_partial;
      for (int i = 0; i < 5; i++)
      begin
         issue(OP_PROGRAM, 8'h80, 8'h10, 11'(i * 64), 12'h041, 11'h002);
         check(ref_seen, i == 4, "partial program limit");
      end
      check(adl_short, 1'b0, "address to data gap too short");
      check(data_seen, wr_data - 16'h0001, "last data word");
      ecc_on <= 1'b1;
      issue(OP_PROGRAM, 8'h80, 8'h10, 11'h100, 12'h043, 11'h002);
      check(ref_seen, 1'b0, "first program of a user area");
      issue(OP_PROGRAM, 8'h80, 8'h10, 11'h140, 12'h043, 11'h002);
      check(ref_seen, 1'b1, "second program of a user area");
      ecc_on <= 1'b0;
      check(to_seen, 1'b0, "program within budget timed out");
      issue(OP_ERASE, 8'h60, 8'hD0, 11'h000, 12'h5A7, 11'h000);
      check(addr_seen[79:32], addr_exp(11'h000, 12'h5A7) >> 32, "erase rows");
   endtask

   task automatic t_timeout;
      busy_cyc = 400;
      issue(OP_PROGRAM, 8'h80, 8'h10, 11'h000, 12'h042, 11'h001);
      check({to_seen, ref_seen}, 2'b10, "busy overrun not flagged");
   endtask

   // Erase left busy long enough to be cut short by a reset
   task automatic t_abort;
      busy_cyc = 400;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{OP_ERASE, 8'h60, 8'hD0, 1'b1, 11'h000, 6'h2A, 12'h043, 11'h000};
      do @(posedge clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      repeat (80) @(posedge clk);
      busy_cyc = 100;
      issue(OP_RESET, 8'hFF, 8'h00, 11'h000, 12'h000, 11'h000);
      check({to_seen, ref_seen, busy, nand_io_oe_n}, 4'b0001, "erase abort");
      check(last_cmd, 8'hFF, "abort sends reset");
   endtask

   task automatic conclude;
      if (bad_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_first_reset();
      t_read();
      t_partial();
      t_abort();
      t_timeout();
      conclude();
   end
   initial
   begin
      #(8 * 30000);
      bad_count++;
      conclude();
   end
endmodule // tb_top
